//--- hw/e1h_pkg.sv
// Shared constants and types for the E1 host access and channel reset block
package e1h_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_NS = 10;
  localparam int unsigned GRST_MAX_NS = 1000;
  localparam int unsigned CH_RST_MAX_NS = 1000;
  localparam logic [6:0] GRST_CYC = 7'(GRST_MAX_NS / CLK_NS);
  localparam int unsigned CH_RST_CYC = CH_RST_MAX_NS / CLK_NS;
  localparam longint unsigned SEC_NS = 64'd1000000000;
  localparam int unsigned SEC_CYC = int'(SEC_NS / CLK_NS);

  // ****************************************
  // Global register offsets
  // ****************************************
  localparam logic [10:0] OFF_ID = 11'h000;
  localparam logic [10:0] OFF_RST = 11'h040;
  localparam logic [10:0] OFF_GCF = 11'h080;
  localparam logic [10:0] OFF_MON = 11'h0C0;
  localparam logic [10:0] OFF_GPIO = 11'h100;
  localparam logic [10:0] OFF_E1_CLOCK_OUTPUT_CTRL = 11'h1C0;
  localparam logic [10:0] OFF_REF_OUTPUT_CONFIG = 11'h200;
  localparam logic [10:0] OFF_REF_A_SOURCE_SELECT = 11'h240;
  localparam logic [10:0] OFF_REF_B_SOURCE_SELECT = 11'h280;
  localparam logic [10:0] OFF_IRQ1 = 11'h2C0;
  localparam logic [10:0] OFF_IRQ2 = 11'h300;
  localparam logic [10:0] OFF_IRQ3 = 11'h340;
  localparam logic [10:0] OFF_IRQ0 = 11'h380;
  localparam logic [10:0] OFF_TMR = 11'h3C0;

  // ****************************************
  // Per-channel register offsets within a 64-byte block
  // ****************************************
  localparam logic [5:0] CH_OFF_CFG = 6'h01;
  localparam logic [5:0] CH_OFF_TX_CONFIG_REGISTER_0 = 6'h04;
  localparam logic [5:0] CH_OFF_RX_CONFIG_REGISTER_0 = 6'h0A;
  localparam logic [5:0] CH_OFF_MODE = 6'h3F;
  localparam logic [4:0] CH0_BLK = 5'h1F;
  localparam logic [4:0] LAST_CH_BLK = 5'h14;
  localparam int unsigned NUM_CH = 22;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned CHANNEL_SOFT_RESET_BIT_BIT = 1;
  localparam int unsigned HIZ_BIT = 6;
  localparam int unsigned GCF_GLOBAL_IRQ_MASK = 1;
  localparam int unsigned GCF_TM_IM = 0;
  localparam int unsigned MODE_E1_BIT = 0;
  localparam int unsigned MODE_FMT_BIT = 1;

  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [7:0] TX_CONFIG_REGISTER_0_RST = 8'h00;
  localparam logic [7:0] RX_CONFIG_REGISTER_0_RST = 8'h40;
  localparam logic [4:0] GCF_RST = 5'h03;
  localparam logic [2:0] TERM_OFF = 3'h0;
  localparam logic [2:0] TERM_120 = 3'h2;
  localparam logic [2:0] TERM_75 = 3'h3;
  localparam logic [1:0] IRQ_OD = 2'h0;
  localparam logic [1:0] IRQ_PP_LOW = 2'h1;
  localparam logic [1:0] IRQ_PP_HIGH = 2'h2;
  localparam logic [4:0] SER_HDR_LAST = 5'h0F;
  localparam logic [4:0] SER_DATA_LAST = 5'h17;
  localparam logic [4:0] SER_BITS = 5'h18;

  // ****************************************
  // Access sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RD1 = 3'h1,
    ST_RD2 = 3'h3,
    ST_HOLD = 3'h2,
    ST_WR = 3'h6
  } e1h_acc_t;

endpackage

//--- hw/e1h_chan_mem.sv
// Per-channel configuration byte store with registered read data
`timescale 1ns/100ps
`default_nettype none
module e1h_chan_mem (
  // Clock
  input wire logic mclk,
  // Write port
  input wire logic we,
  input wire logic [5:0] waddr,
  input wire logic [7:0] wdata,
  // Read port
  input wire logic [5:0] raddr,
  output logic [7:0] rdata
);

  typedef struct packed {
    logic [63:0][7:0] mem;
    logic [7:0] rdata;
  } e1h_mem_st_t;

  e1h_mem_st_t s_r;
  e1h_mem_st_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = s_r.mem[raddr];
    if (we) begin
      s_nxt.mem[waddr] = wdata;
    end
  end

  always_ff @(posedge mclk) begin
    s_r <= s_nxt;
  end

  assign rdata = s_r.rdata;

endmodule
`default_nettype wire

//--- hw/e1h_host_ctrl.sv
// Host register access, global registers and per-channel soft reset
`timescale 1ns/100ps
`default_nettype none
module e1h_host_ctrl #(
  parameter logic [7:0] ID_VALUE = 8'h5A, // Arbitrary value
  parameter int unsigned SEC_CYC = e1h_pkg::SEC_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Interface straps
  input wire logic serial_sel,
  input wire logic strobe_style_strap,
  input wire logic bus_multiplex_strap,
  // Host bus
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_data_in,
  input wire logic data_strobe_n,
  input wire logic rw,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic address_strobe,
  input wire logic [10:0] addr_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe,
  output logic resp_o,
  output logic resp_oe,
  // Protection pins
  input wire logic oe_pin,
  input wire logic rx_impedance_mode_pin,
  // Channel side
  input wire logic [21:0] chan_irq,
  output logic [21:0] chan_soft_rst,
  output logic [21:0] e1_mode,
  output logic [21:0] sys_fmt_sel,
  output logic [21:0] tx_line_en,
  output logic [21:0] rx_line_en,
  output logic [65:0] tx_term_code,
  output logic [65:0] rx_term_code,
  // Global outputs
  output logic irq_o,
  output logic irq_oe,
  output logic [1:0] gpio_o,
  output logic [1:0] gpio_oe,
  output logic gcf_copy,
  output logic [5:0] mon_sel,
  output logic [1:0] clke1_ctrl,
  output logic [6:0] ref_cfg,
  output logic [6:0] ref_a_cfg,
  output logic [6:0] ref_b_cfg
);

  typedef struct packed {
    logic mode_ser;
    logic mode_rw;
    logic mode_mux;
    e1h_pkg::e1h_acc_t st;
    logic [10:0] addr;
    logic [7:0] wdata;
    logic is_rd;
    logic [7:0] alat;
    logic strobe_q;
    logic sclk_q;
    logic [15:0] sh;
    logic [4:0] bitcnt;
    logic [7:0] sdo_sh;
    logic [7:0] data_o;
    logic data_oe;
    logic resp_o;
    logic resp_oe;
    logic [4:0] global_configuration;
    logic [5:0] mon;
    logic [3:0] gpio;
    logic [1:0] e1_clock_output_ctrl;
    logic [6:0] ref_output_config;
    logic [6:0] ref_a_source_select;
    logic [6:0] ref_b_source_select;
    logic [26:0] tmr;
    logic tm_flag;
    logic [6:0] grst_cnt;
    logic [5:0] ptr;
    logic cr_busy;
    logic cr_slot;
    logic [4:0] cr_ch;
    logic [21:0] channel_soft_reset_bit;
    logic [21:0] e1;
    logic [21:0] fmt;
    logic [21:0] tx_oe;
    logic [21:0] rx_hiz;
    logic [65:0] tx_term;
    logic [65:0] rx_term;
    logic irq_o;
    logic irq_oe;
  } e1h_top_st_t;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [4:0] chan_of(input logic [10:0] a);
    return (a[10:6] == e1h_pkg::CH0_BLK) ? 5'h00 : 5'(a[10:6] + 5'h01);
  endfunction

  function automatic logic chan_hit(input logic [10:0] a, input logic [5:0] off);
    return (a[5:0] == off) && ((a[10:6] <= e1h_pkg::LAST_CH_BLK) ||
                               (a[10:6] == e1h_pkg::CH0_BLK));
  endfunction

  function automatic logic [5:0] mem_idx(input logic slot, input logic [4:0] ch);
    return {slot, ch};
  endfunction

  function automatic logic [4:0] first_set(input logic [21:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 21; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  function automatic e1h_top_st_t defaults(input e1h_top_st_t cur);
    e1h_top_st_t d;
    d = '0;
    d.mode_ser = cur.mode_ser;
    d.mode_rw = cur.mode_rw;
    d.mode_mux = cur.mode_mux;
    d.st = e1h_pkg::ST_IDLE;
    d.global_configuration = e1h_pkg::GCF_RST;
    d.rx_hiz = '1;
    d.grst_cnt = e1h_pkg::GRST_CYC;
    d.irq_oe = 1'b0;
    return d;
  endfunction

  e1h_top_st_t s_r;
  e1h_top_st_t s_nxt;
  logic [7:0] mem_rdata;
  logic mem_we;
  logic [5:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [5:0] mem_raddr;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic strobe;
    logic req_rd;
    logic req_wr;
    logic [10:0] req_addr;
    logic [7:0] req_wdata;
    logic [4:0] ch;
    logic [7:0] rd;
    logic [15:0] hdr;
    logic active;
    strobe = 1'b0;
    req_rd = 1'b0;
    req_wr = 1'b0;
    req_addr = 11'h000;
    req_wdata = 8'h00;
    ch = chan_of(s_r.addr);
    rd = 8'h00;
    hdr = {s_r.sh[14:0], serial_data_in};
    active = 1'b0;
    s_nxt = s_r;
    mem_we = 1'b0;
    mem_waddr = 6'h00;
    mem_wdata = 8'h00;
    mem_raddr = mem_idx(s_r.addr[5:0] == e1h_pkg::CH_OFF_RX_CONFIG_REGISTER_0, ch);

    // Front ends: parallel strobes and serial shifter
    if (!s_r.mode_ser) begin
      strobe = !cs_n && (s_r.mode_rw ? (!rd_n || !wr_n) : !data_strobe_n);
    end
    s_nxt.strobe_q = strobe;
    s_nxt.sclk_q = sclk;
    if (s_r.mode_mux && address_strobe) begin
      s_nxt.alat = data_i;
    end
    if (!s_r.mode_ser) begin
      s_nxt.resp_oe = !cs_n;
      if (strobe && !s_r.strobe_q) begin
        req_rd = s_r.mode_rw ? !rd_n : rw;
        req_wr = !req_rd;
        req_addr = s_r.mode_mux ? {addr_i[10:8], s_r.alat} : addr_i;
        req_wdata = data_i;
      end
    end else if (cs_n) begin
      s_nxt.bitcnt = 5'h00;
      s_nxt.resp_oe = 1'b0;
    end else begin
      if (sclk && !s_r.sclk_q && s_r.bitcnt < e1h_pkg::SER_BITS) begin
        s_nxt.sh = hdr;
        s_nxt.bitcnt = 5'(s_r.bitcnt + 5'h01);
        if (s_r.bitcnt == e1h_pkg::SER_HDR_LAST) begin
          s_nxt.addr = hdr[10:0];
          s_nxt.is_rd = hdr[15];
          req_rd = hdr[15];
          req_addr = hdr[10:0];
        end
        if (s_r.bitcnt == e1h_pkg::SER_DATA_LAST && !s_r.is_rd) begin
          req_wr = 1'b1;
          req_addr = s_r.addr;
          req_wdata = hdr[7:0];
        end
      end
      if (!sclk && s_r.sclk_q && s_r.is_rd && s_r.bitcnt > e1h_pkg::SER_HDR_LAST) begin
        s_nxt.resp_o = s_r.sdo_sh[7];
        s_nxt.sdo_sh = {s_r.sdo_sh[6:0], 1'b0};
      end
    end

    // Per-channel soft reset sequencer
    if (s_r.grst_cnt == 7'h00) begin
      if (s_r.cr_busy) begin
        mem_we = 1'b1;
        mem_waddr = mem_idx(s_r.cr_slot, s_r.cr_ch);
        mem_wdata = s_r.cr_slot ? e1h_pkg::RX_CONFIG_REGISTER_0_RST : e1h_pkg::TX_CONFIG_REGISTER_0_RST;
        s_nxt.cr_slot = 1'b1;
        if (s_r.cr_slot) begin
          s_nxt.cr_busy = 1'b0;
          s_nxt.channel_soft_reset_bit[s_r.cr_ch] = 1'b0;
          s_nxt.fmt[s_r.cr_ch] = 1'b0;
          s_nxt.tx_oe[s_r.cr_ch] = 1'b0;
          s_nxt.rx_hiz[s_r.cr_ch] = 1'b1;
          s_nxt.tx_term[s_r.cr_ch*3 +: 3] = e1h_pkg::TX_CONFIG_REGISTER_0_RST[2:0];
          s_nxt.rx_term[s_r.cr_ch*3 +: 3] = e1h_pkg::RX_CONFIG_REGISTER_0_RST[2:0];
        end
      end else if (|s_r.channel_soft_reset_bit) begin
        s_nxt.cr_busy = 1'b1;
        s_nxt.cr_slot = 1'b0;
        s_nxt.cr_ch = first_set(s_r.channel_soft_reset_bit);
      end
    end

    // Access sequencer
    case (s_r.st)
      e1h_pkg::ST_IDLE: begin
        if ((req_rd || req_wr) && s_r.grst_cnt == 7'h00) begin
          s_nxt.addr = req_addr;
          s_nxt.is_rd = req_rd;
          s_nxt.wdata = req_wdata;
          s_nxt.st = req_rd ? e1h_pkg::ST_RD1 : e1h_pkg::ST_WR;
        end
      end
      e1h_pkg::ST_RD1: begin
        s_nxt.st = e1h_pkg::ST_RD2;
      end
      e1h_pkg::ST_RD2: begin
        case (s_r.addr)
          e1h_pkg::OFF_ID: rd = ID_VALUE;
          e1h_pkg::OFF_GCF: rd = {3'h0, s_r.global_configuration};
          e1h_pkg::OFF_MON: rd = {2'h0, s_r.mon};
          e1h_pkg::OFF_GPIO: rd = {4'h0, s_r.gpio};
          e1h_pkg::OFF_E1_CLOCK_OUTPUT_CTRL: rd = {4'h0, s_r.e1_clock_output_ctrl, 2'h0};
          e1h_pkg::OFF_REF_OUTPUT_CONFIG: rd = {1'h0, s_r.ref_output_config};
          e1h_pkg::OFF_REF_A_SOURCE_SELECT: rd = {1'h0, s_r.ref_a_source_select};
          e1h_pkg::OFF_REF_B_SOURCE_SELECT: rd = {1'h0, s_r.ref_b_source_select};
          e1h_pkg::OFF_IRQ1: rd = chan_irq[8:1];
          e1h_pkg::OFF_IRQ2: rd = chan_irq[16:9];
          e1h_pkg::OFF_IRQ3: rd = {3'h0, chan_irq[21:17]};
          e1h_pkg::OFF_IRQ0: rd = {chan_irq[0], 7'h00};
          e1h_pkg::OFF_TMR: begin
            rd = {7'h00, s_r.tm_flag};
            s_nxt.tm_flag = 1'b0;
          end
          default: begin
            if (chan_hit(s_r.addr, e1h_pkg::CH_OFF_CFG)) begin
              rd = {6'h00, s_r.channel_soft_reset_bit[ch], 1'b0};
            end else if (chan_hit(s_r.addr, e1h_pkg::CH_OFF_TX_CONFIG_REGISTER_0) ||
                         chan_hit(s_r.addr, e1h_pkg::CH_OFF_RX_CONFIG_REGISTER_0)) begin
              rd = mem_rdata;
            end else if (chan_hit(s_r.addr, e1h_pkg::CH_OFF_MODE)) begin
              rd = {6'h00, s_r.fmt[ch], s_r.e1[ch]};
            end
          end
        endcase
        if (s_r.mode_ser) begin
          s_nxt.sdo_sh = rd;
          s_nxt.resp_oe = 1'b1;
          s_nxt.st = e1h_pkg::ST_IDLE;
        end else begin
          s_nxt.data_o = rd;
          s_nxt.data_oe = 1'b1;
          s_nxt.st = e1h_pkg::ST_HOLD;
        end
      end
      e1h_pkg::ST_WR: begin
        if (!s_r.cr_busy) begin
          s_nxt.st = s_r.mode_ser ? e1h_pkg::ST_IDLE : e1h_pkg::ST_HOLD;
          case (s_r.addr)
            e1h_pkg::OFF_RST: s_nxt = defaults(s_r);
            e1h_pkg::OFF_GCF: s_nxt.global_configuration = s_r.wdata[4:0];
            e1h_pkg::OFF_MON: s_nxt.mon = s_r.wdata[5:0];
            e1h_pkg::OFF_GPIO: s_nxt.gpio = s_r.wdata[3:0];
            e1h_pkg::OFF_E1_CLOCK_OUTPUT_CTRL: s_nxt.e1_clock_output_ctrl = s_r.wdata[3:2];
            e1h_pkg::OFF_REF_OUTPUT_CONFIG: s_nxt.ref_output_config = s_r.wdata[6:0];
            e1h_pkg::OFF_REF_A_SOURCE_SELECT: s_nxt.ref_a_source_select = s_r.wdata[6:0];
            e1h_pkg::OFF_REF_B_SOURCE_SELECT: s_nxt.ref_b_source_select = s_r.wdata[6:0];
            default: begin
              if (chan_hit(s_r.addr, e1h_pkg::CH_OFF_CFG)) begin
                if (s_r.wdata[e1h_pkg::CHANNEL_SOFT_RESET_BIT_BIT]) begin
                  s_nxt.channel_soft_reset_bit[ch] = 1'b1;
                end
              end else if (chan_hit(s_r.addr, e1h_pkg::CH_OFF_TX_CONFIG_REGISTER_0)) begin
                mem_we = 1'b1;
                mem_waddr = mem_idx(1'b0, ch);
                mem_wdata = s_r.wdata;
                s_nxt.tx_oe[ch] = s_r.wdata[e1h_pkg::HIZ_BIT];
                s_nxt.tx_term[ch*3 +: 3] = s_r.wdata[2:0];
              end else if (chan_hit(s_r.addr, e1h_pkg::CH_OFF_RX_CONFIG_REGISTER_0)) begin
                mem_we = 1'b1;
                mem_waddr = mem_idx(1'b1, ch);
                mem_wdata = s_r.wdata;
                s_nxt.rx_hiz[ch] = s_r.wdata[e1h_pkg::HIZ_BIT];
                s_nxt.rx_term[ch*3 +: 3] = s_r.wdata[2:0];
              end else if (chan_hit(s_r.addr, e1h_pkg::CH_OFF_MODE)) begin
                s_nxt.e1[ch] = s_r.wdata[e1h_pkg::MODE_E1_BIT];
                s_nxt.fmt[ch] = s_r.wdata[e1h_pkg::MODE_FMT_BIT];
              end
            end
          endcase
        end
      end
      e1h_pkg::ST_HOLD: begin
        if (!strobe) begin
          s_nxt.data_oe = 1'b0;
          s_nxt.st = e1h_pkg::ST_IDLE;
        end
      end
      default: begin
        s_nxt.st = e1h_pkg::ST_IDLE;
      end
    endcase

    // Handshake level for parallel modes
    if (!s_r.mode_ser) begin
      s_nxt.resp_o = s_r.mode_rw ? (s_nxt.st == e1h_pkg::ST_HOLD) :
                     (s_nxt.st != e1h_pkg::ST_HOLD);
    end

    // Whole-device soft reset walk over the channel store
    if (s_r.grst_cnt != 7'h00) begin
      s_nxt.grst_cnt = 7'(s_r.grst_cnt - 7'h01);
      s_nxt.ptr = 6'(s_r.ptr + 6'h01);
      mem_we = 1'b1;
      mem_waddr = s_r.ptr;
      mem_wdata = s_r.ptr[5] ? e1h_pkg::RX_CONFIG_REGISTER_0_RST : e1h_pkg::TX_CONFIG_REGISTER_0_RST;
    end

    // One-second timer; a set wins over the read clear
    if (s_r.tmr == 27'(SEC_CYC - 1)) begin
      s_nxt.tmr = 27'h0000000;
      s_nxt.tm_flag = 1'b1;
    end else begin
      s_nxt.tmr = 27'(s_r.tmr + 27'h0000001);
    end

    // Interrupt pin
    active = (|chan_irq && !s_nxt.global_configuration[e1h_pkg::GCF_GLOBAL_IRQ_MASK]) ||
             (s_nxt.tm_flag && !s_nxt.global_configuration[e1h_pkg::GCF_TM_IM]);
    case (s_nxt.global_configuration[3:2])
      e1h_pkg::IRQ_PP_LOW: begin
        s_nxt.irq_o = !active;
        s_nxt.irq_oe = 1'b1;
      end
      e1h_pkg::IRQ_PP_HIGH: begin
        s_nxt.irq_o = active;
        s_nxt.irq_oe = 1'b1;
      end
      default: begin
        s_nxt.irq_o = 1'b0;
        s_nxt.irq_oe = active;
      end
    endcase

    // Straps are caught only while reset is held
    if (rst) begin
      s_nxt = defaults(s_r);
      s_nxt.mode_ser = !serial_sel;
      s_nxt.mode_rw = strobe_style_strap;
      s_nxt.mode_mux = bus_multiplex_strap;
    end
  end

  always_ff @(posedge mclk) begin
    s_r <= s_nxt;
  end

  // ****************************************
  // Channel configuration store
  // ****************************************
  e1h_chan_mem u_mem (
    .mclk(mclk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign data_o = s_r.data_o;
  assign data_oe = s_r.data_oe;
  assign resp_o = s_r.resp_o;
  assign resp_oe = s_r.resp_oe;
  assign chan_soft_rst = s_r.channel_soft_reset_bit;
  assign e1_mode = s_r.e1;
  assign sys_fmt_sel = s_r.fmt;
  assign tx_term_code = s_r.tx_term;
  assign irq_o = s_r.irq_o;
  assign irq_oe = s_r.irq_oe;
  assign gpio_o = s_r.gpio[3:2];
  assign gpio_oe = s_r.gpio[1:0];
  assign gcf_copy = s_r.global_configuration[4];
  assign mon_sel = s_r.mon;
  assign clke1_ctrl = s_r.e1_clock_output_ctrl;
  assign ref_cfg = s_r.ref_output_config;
  assign ref_a_cfg = s_r.ref_a_source_select;
  assign ref_b_cfg = s_r.ref_b_source_select;
  // Protection pins act without a clock edge
  assign tx_line_en = s_r.tx_oe & ~s_r.channel_soft_reset_bit & {22{oe_pin}};
  assign rx_line_en = ~s_r.rx_hiz & ~s_r.channel_soft_reset_bit & {22{oe_pin}};
  assign rx_term_code = rx_impedance_mode_pin ? {22{e1h_pkg::TERM_OFF}} : s_r.rx_term;

endmodule
`default_nettype wire

//--- dv/e1h_host_ctrl_chk.sv
// Port-level assertions for the host control block
`timescale 1ns/100ps
`default_nettype none
module e1h_host_ctrl_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Straps and host strobes
  input wire logic serial_sel,
  input wire logic strobe_style_strap,
  input wire logic bus_multiplex_strap,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [10:0] addr_i,
  // Responses
  input wire logic data_oe,
  input wire logic resp_o,
  input wire logic resp_oe,
  // Protection and channel side
  input wire logic oe_pin,
  input wire logic rx_impedance_mode_pin,
  input wire logic [21:0] chan_soft_rst,
  input wire logic [21:0] sys_fmt_sel,
  input wire logic [21:0] tx_line_en,
  input wire logic [21:0] rx_line_en,
  input wire logic [65:0] tx_term_code,
  input wire logic [65:0] rx_term_code
);
  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic rwp;
  assign rwp = serial_sel && strobe_style_strap && !bus_multiplex_strap;
  sequence rd_take; rwp && !cs_n && $fell(rd_n); endsequence
  sequence wr_take; rwp && !cs_n && $fell(wr_n) && addr_i != 11'h040; endsequence
  sequence rd_walk; !data_oe ##2 (data_oe && resp_o); endsequence
  chk_line_force_off: assert property (!oe_pin |-> tx_line_en == 0 && rx_line_en == 0)
    else $error("line enables active while output enable pin low");
  chk_rx_code_ignored: assert property (rx_impedance_mode_pin |-> rx_term_code == 0)
    else $error("receive termination code passed with open impedance pin");
  chk_read_latency: assert property (rd_take |-> ##1 rd_walk)
    else $error("read data and ready not at third edge");
  chk_write_latency: assert property (wr_take |-> ##1 !resp_o ##[1:3] resp_o)
    else $error("write ready outside two to four edges");
  chk_ready_stands: assert property (rwp && resp_o && !cs_n && !(rd_n && wr_n) |=> resp_o)
    else $error("ready dropped while strobe held");
  chk_resp_drive: assert property (serial_sel && $fell(cs_n) |=> resp_oe)
    else $error("ready pin not driven after chip select");
  chk_chan_self_clear: assert property ($rose(chan_soft_rst[1]) |-> ##[1:100] !chan_soft_rst[1])
    else $error("channel reset not cleared within limit");
  chk_chan_defaults: assert property ($fell(chan_soft_rst[1]) |->
    ##[0:1] (!sys_fmt_sel[1] && !tx_line_en[1] && tx_term_code[5:3] == 3'h0))
    else $error("channel defaults missing after channel reset");
  chk_others_kept: assert property (chan_soft_rst[1] |->
    $stable(tx_term_code[65:6]) && $stable(tx_term_code[2:0]))
    else $error("other channel changed during channel reset");
endmodule
bind e1h_host_ctrl e1h_host_ctrl_chk e1h_host_ctrl_chk_inst (.mclk, .rst, .serial_sel,
  .strobe_style_strap, .bus_multiplex_strap, .cs_n, .rd_n, .wr_n, .addr_i, .data_oe, .resp_o,
  .resp_oe, .oe_pin, .rx_impedance_mode_pin, .chan_soft_rst, .sys_fmt_sel, .tx_line_en,
  .rx_line_en, .tx_term_code, .rx_term_code);
`default_nettype wire

//--- dv/e1h_host_model.sv
// Host processor model for the parallel bus in both strobe styles
`timescale 1ns/100ps
`default_nettype none
module e1h_host_model (
  // Clock
  input wire logic mclk,
  // Bus to the device
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic [10:0] addr,
  output logic [7:0] bus,
  // Device response
  input wire logic [7:0] data_o,
  input wire logic data_oe,
  input wire logic resp_o
);
  // ****************************************
  // Bus cycles
  // ****************************************
  logic [7:0] hd = 8'h00;
  logic hoe = 1'b0;
  logic late = 1'b0;
  // Set for the data-strobe style, where acknowledge is active low
  logic ack_lo = 1'b0;
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 11'h000;
  end
  // Released bus shows the inverse of the last byte
  assign bus = data_oe ? data_o : (hoe ? hd : ~hd);
  task automatic xfer(input logic w, input logic [10:0] a, input logic [7:0] d,
                      input bit need, output logic [7:0] q);
    int n;
    @(negedge mclk);
    addr = a;
    hd = d;
    hoe = w;
    cs_n = 1'b0;
    if (w) wr_n = 1'b0;
    else rd_n = 1'b0;
    n = 0;
    @(posedge mclk);
    while (resp_o !== !ack_lo && n < 20) begin
      @(posedge mclk);
      n++;
    end
    q = data_o;
    late = need && (n >= 20);
    @(negedge mclk);
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    hoe = 1'b0;
    @(negedge mclk);
  endtask
endmodule
`default_nettype wire

//--- dv/tb_e1h_host_ctrl.sv
// Self-checking testbench for the host control block
`timescale 1ns/100ps
`default_nettype none
module tb_e1h_host_ctrl;
  // ****************************************
  // Signals and helpers
  // ****************************************
  localparam logic [7:0] IDENT_V = 8'hA7; // Arbitrary value
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic style = 1'b1;
  logic oe_pin = 1'b1;
  logic imp_pin = 1'b0;
  logic [21:0] chan_irq = 22'h0;
  logic cs_n, rd_n, wr_n, data_oe, resp_o, resp_oe, irq_o, irq_oe, gcf_copy;
  logic [5:0] mon_sel;
  logic [6:0] ref_cfg, ref_b_cfg;
  logic [10:0] addr;
  logic [7:0] bus, data_o;
  logic [1:0] gpio_o, gpio_oe;
  logic [21:0] chan_soft_rst, e1_mode, sys_fmt_sel, tx_line_en, rx_line_en;
  logic [65:0] tx_term_code, rx_term_code;
  int failures = 0;
  int total_checks = 0;
  always #5 mclk = ~mclk;
  e1h_host_ctrl #(.ID_VALUE(IDENT_V), .SEC_CYC(50)) e1h_host_ctrl_inst (.mclk(mclk), .rst(rst),
    .serial_sel(1'b1), .strobe_style_strap(style), .bus_multiplex_strap(1'b0), .cs_n(cs_n),
    .sclk(1'b0), .serial_data_in(1'b0), .data_strobe_n(rd_n & wr_n), .rw(wr_n), .rd_n(rd_n),
    .wr_n(wr_n), .address_strobe(1'b0), .addr_i(addr), .data_i(bus), .data_o(data_o),
    .data_oe(data_oe), .resp_o(resp_o), .resp_oe(resp_oe), .oe_pin(oe_pin),
    .rx_impedance_mode_pin(imp_pin), .chan_irq(chan_irq), .chan_soft_rst(chan_soft_rst),
    .e1_mode(e1_mode), .sys_fmt_sel(sys_fmt_sel), .tx_line_en(tx_line_en),
    .rx_line_en(rx_line_en), .tx_term_code(tx_term_code), .rx_term_code(rx_term_code),
    .irq_o(irq_o), .irq_oe(irq_oe), .gpio_o(gpio_o), .gpio_oe(gpio_oe), .gcf_copy(gcf_copy),
    .mon_sel(mon_sel), .clke1_ctrl(), .ref_cfg(ref_cfg), .ref_a_cfg(), .ref_b_cfg(ref_b_cfg));
  e1h_host_model e1h_host_model_inst (.mclk(mclk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .addr(addr), .bus(bus), .data_o(data_o), .data_oe(data_oe), .resp_o(resp_o));
  task automatic give_verdict();
    if (e1h_host_model_inst.late) failures++;
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [10:0] a, input logic [7:0] d, input bit need = 1'b1);
    logic [7:0] q;
    e1h_host_model_inst.xfer(1'b1, a, d, need, q);
    if (e1h_host_model_inst.late) give_verdict();
  endtask
  task automatic rd(input logic [10:0] a, input logic [7:0] e);
    logic [7:0] q;
    e1h_host_model_inst.xfer(1'b0, a, 8'h00, 1'b1, q);
    if (e1h_host_model_inst.late) give_verdict();
    cmp(q, e);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_map();
    rd(11'h000, IDENT_V);
    wr(11'h000, 8'hFF);
    rd(11'h000, IDENT_V);
    rd(11'h080, 8'h03);
    wr(11'h080, 8'h1F);
    cmp({7'h0, gcf_copy}, 8'h01);
    rd(11'h080, 8'h1F);
    rd(11'h541, 8'h00);
    rd(11'h400, 8'h00);
    wr(11'h100, 8'h0E);
    cmp({4'h0, gpio_o, gpio_oe}, 8'h0E);
    wr(11'h200, 8'h7F);
    cmp({1'h0, ref_cfg}, 8'h7F);
    rd(11'h200, 8'h7F);
    wr(11'h280, 8'h55);
    cmp({1'h0, ref_b_cfg}, 8'h55);
    rd(11'h280, 8'h55);
  endtask
  task automatic t_term();
    wr(11'h00A, 8'h02);
    cmp({5'h0, rx_term_code[5:3]}, 8'h02);
    wr(11'h00A, 8'h03);
    cmp({5'h0, rx_term_code[5:3]}, 8'h03);
    wr(11'h004, 8'h43);
    wr(11'h044, 8'h42);
    wr(11'h03F, 8'h03);
    cmp({5'h0, tx_term_code[5:3]}, 8'h03);
    cmp({6'h0, tx_line_en[1], rx_line_en[1]}, 8'h03);
    imp_pin = 1'b1;
    @(negedge mclk);
    cmp({5'h0, rx_term_code[5:3]}, 8'h00);
    imp_pin = 1'b0;
    oe_pin = 1'b0;
    @(negedge mclk);
    cmp({6'h0, tx_line_en[1], rx_line_en[1]}, 8'h00);
    oe_pin = 1'b1;
  endtask
  task automatic t_chan_reset();
    int n;
    wr(11'h001, 8'h02);
    for (n = 0; n < 100 && chan_soft_rst[1] !== 1'b0; n++) @(negedge mclk);
    if (n == 100) begin
      failures++;
      give_verdict();
    end
    cmp({5'h0, tx_term_code[5:3]}, 8'h00);
    cmp({5'h0, e1_mode[1], sys_fmt_sel[1], rx_line_en[1]}, 8'h04);
    cmp({5'h0, tx_term_code[8:6]}, 8'h02);
    rd(11'h080, 8'h1F);
    rd(11'h001, 8'h00);
  endtask
  task automatic t_irq();
    chan_irq = 22'h2B5A6D;
    rd(11'h2C0, chan_irq[8:1]);
    rd(11'h300, chan_irq[16:9]);
    rd(11'h340, {3'h0, chan_irq[21:17]});
    rd(11'h380, {chan_irq[0], 7'h00});
  endtask
  task automatic t_timer();
    int n;
    wr(11'h080, 8'h02);
    rd(11'h3C0, 8'h01);
    // Wait for the next expiry on the open-drain interrupt pin
    for (n = 0; n < 60 && irq_oe !== 1'b1; n++) @(negedge mclk);
    if (n == 60) begin
      failures++;
      give_verdict();
    end
    cmp({6'h0, irq_o, irq_oe}, 8'h01);
    rd(11'h3C0, 8'h01);
    rd(11'h3C0, 8'h00);
    cmp({6'h0, irq_o, irq_oe}, 8'h00);
  endtask
  task automatic t_global_reset();
    wr(11'h040, 8'hA5, 1'b0);
    repeat (110) @(negedge mclk);
    rd(11'h080, 8'h03);
    rd(11'h00A, 8'h40);
    cmp({6'h0, gpio_oe}, 8'h00);
  endtask
  task automatic t_ds_mode();
    rst = 1'b1;
    style = 1'b0;
    e1h_host_model_inst.ack_lo = 1'b1;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    repeat (105) @(negedge mclk);
    cmp({7'h0, resp_o}, 8'h01);
    rd(11'h000, IDENT_V);
    wr(11'h0C0, 8'h2A);
    cmp({2'h0, mon_sel}, 8'h2A);
    rd(11'h0C0, 8'h2A);
  endtask
  initial begin
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    repeat (105) @(negedge mclk);
    t_map();
    t_term();
    t_chan_reset();
    t_irq();
    t_timer();
    t_global_reset();
    t_ds_mode();
    give_verdict();
  end
endmodule
`default_nettype wire
